// File: rtl/dspdp_datapath.sv
`timescale 1ns/1ps
module dspdp_datapath (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Operation from the instruction sequencer.
	input wire logic op_valid,
	input wire dspdp_pkg::dspdp_op_e op_code,
	input wire logic [2:0] dst_sel,
	input wire logic [2:0] src_a_sel,
	input wire logic [2:0] src_b_sel,
	input wire dspdp_pkg::dspdp_part_e part_sel,
	input wire dspdp_pkg::dspdp_psc_e prescale,
	input wire logic [5:0] shift_amt,
	// Data memory load bus.
	input wire logic [15:0] load_data,
	// Data memory store bus.
	output logic [15:0] store_data,
	output logic store_valid,
	// Result and status of the last register write.
	output logic [39:0] result,
	output logic result_valid,
	output logic flag_zero,
	output logic flag_neg
);

	// ***********************************************************************
	// Declarations
	// ***********************************************************************

	logic [39:0] bank [dspdp_pkg::NUM_REGS];
	logic [39:0] next_bank [dspdp_pkg::NUM_REGS];
	logic [39:0] opa;
	logic [39:0] opb;
	logic [39:0] opd;
	logic [15:0] mul_x;
	logic [15:0] mul_y;
	logic signed [31:0] product;
	logic [39:0] product_ext;
	logic [39:0] addend_scaled;
	logic [39:0] mac_val;
	logic [39:0] alu_val;
	logic [39:0] calc_val;
	logic [39:0] wr_val;
	logic wr_en;
	logic [15:0] next_store_data;
	logic next_store_valid;
	logic [39:0] next_result;
	logic next_result_valid;
	logic next_flag_zero;
	logic next_flag_neg;
	dspdp_shift_if shift_bus ();

	// ***********************************************************************
	// Helper functions
	// ***********************************************************************

	// Places a new value into the selected parts of an old value and keeps the rest.
	function automatic logic [39:0] merge_parts(
		input logic [39:0] old_val,
		input logic [39:0] new_val,
		input dspdp_pkg::dspdp_part_e part
	);
		logic [39:0] merged;
		merged = new_val;
		unique case (part)
			dspdp_pkg::PART_LOW: begin
				merged = {old_val[dspdp_pkg::EXT_MSB:dspdp_pkg::HIGH_LSB], new_val[dspdp_pkg::LOW_MSB:dspdp_pkg::LOW_LSB]};
			end
			dspdp_pkg::PART_HIGH: begin
				merged = {old_val[dspdp_pkg::EXT_MSB:dspdp_pkg::EXT_LSB],
					new_val[dspdp_pkg::HIGH_MSB:dspdp_pkg::HIGH_LSB],
					old_val[dspdp_pkg::LOW_MSB:dspdp_pkg::LOW_LSB]};
			end
			dspdp_pkg::PART_EXT: begin
				merged = {new_val[dspdp_pkg::EXT_MSB:dspdp_pkg::EXT_LSB], old_val[dspdp_pkg::HIGH_MSB:dspdp_pkg::LOW_LSB]};
			end
			dspdp_pkg::PART_HL: begin
				merged = {old_val[dspdp_pkg::EXT_MSB:dspdp_pkg::EXT_LSB], new_val[dspdp_pkg::HIGH_MSB:dspdp_pkg::LOW_LSB]};
			end
			default: begin
				merged = new_val;
			end
		endcase
		return merged;
	endfunction

	// Lines a 16-bit memory word up with the part it is loaded into.
	function automatic logic [39:0] align_load(
		input logic [15:0] word,
		input dspdp_pkg::dspdp_part_e part
	);
		logic [39:0] aligned;
		aligned = {{24{word[15]}}, word};
		unique case (part)
			dspdp_pkg::PART_LOW: aligned = {24'h00_0000, word};
			dspdp_pkg::PART_HIGH: aligned = {8'h00, word, 16'h0000};
			dspdp_pkg::PART_EXT: aligned = {word[7:0], 32'h0000_0000};
			dspdp_pkg::PART_HL: aligned = {{8{word[15]}}, word, 16'h0000};
			default: aligned = {{24{word[15]}}, word};
		endcase
		return aligned;
	endfunction

	// ***********************************************************************
	// Operand read and arithmetic units
	// ***********************************************************************

	// Operand reads from the working registers.
	assign opa = bank[src_a_sel];
	assign opb = bank[src_b_sel];
	assign opd = bank[dst_sel];

	// The multiplier takes the high parts of both sources as signed 16-bit values.
	assign mul_x = opa[dspdp_pkg::HIGH_MSB:dspdp_pkg::HIGH_LSB];
	assign mul_y = opb[dspdp_pkg::HIGH_MSB:dspdp_pkg::HIGH_LSB];
	assign product = $signed(mul_x) * $signed(mul_y);
	assign product_ext = {{8{product[31]}}, product};

	// The pre-scaler shifts the destination value before it is accumulated.
	always_comb begin
		unique case (prescale)
			dspdp_pkg::PSC_BY1: addend_scaled = $unsigned($signed(opd) >>> dspdp_pkg::PSC_SHORT);
			dspdp_pkg::PSC_BY16: addend_scaled = $unsigned($signed(opd) >>> dspdp_pkg::PSC_LONG);
			default: addend_scaled = opd;
		endcase
	end

	// Accumulation adds or subtracts the product; the sum wraps at 40 bits.
	assign mac_val = (op_code == dspdp_pkg::OP_MAC_SUB) ? addend_scaled - product_ext : addend_scaled + product_ext;

	// Logic/arithmetic unit on one or two 40-bit operands.
	always_comb begin
		unique case (op_code)
			dspdp_pkg::OP_ADD: alu_val = opa + opb;
			dspdp_pkg::OP_SUB: alu_val = opa - opb;
			dspdp_pkg::OP_AND: alu_val = opa & opb;
			dspdp_pkg::OP_OR: alu_val = opa | opb;
			dspdp_pkg::OP_XOR: alu_val = opa ^ opb;
			dspdp_pkg::OP_NEG: alu_val = 40'h00_0000_0000 - opa;
			default: alu_val = opa;
		endcase
	end

	// Request to the barrel shifter.
	assign shift_bus.operand = opa;
	assign shift_bus.amount = shift_amt;
	assign shift_bus.mode = (op_code == dspdp_pkg::OP_SRA) ? dspdp_pkg::SH_ARITH :
		(op_code == dspdp_pkg::OP_SRL) ? dspdp_pkg::SH_LOGIC : dspdp_pkg::SH_LEFT;

	// Barrel shifter instance.
	dspdp_shifter u_shifter (
		.sh(shift_bus)
	);

	// ***********************************************************************
	// Write-back selection
	// ***********************************************************************

	// Picks the value and parts that the accepted operation writes this cycle.
	always_comb begin
		calc_val = alu_val;
		wr_en = 1'b0;
		wr_val = opd;
		next_store_data = store_data;
		next_store_valid = 1'b0;
		if (op_valid) begin
			unique case (op_code)
				dspdp_pkg::OP_MAC_ADD, dspdp_pkg::OP_MAC_SUB: begin
					calc_val = mac_val;
					wr_en = 1'b1;
				end
				dspdp_pkg::OP_SHL, dspdp_pkg::OP_SRA, dspdp_pkg::OP_SRL: begin
					calc_val = shift_bus.result;
					wr_en = 1'b1;
				end
				dspdp_pkg::OP_LOAD: begin
					calc_val = align_load(load_data, part_sel);
					wr_en = 1'b1;
				end
				dspdp_pkg::OP_STORE: begin
					next_store_valid = 1'b1;
					unique case (part_sel)
						dspdp_pkg::PART_HIGH, dspdp_pkg::PART_HL: begin
							next_store_data = opa[dspdp_pkg::HIGH_MSB:dspdp_pkg::HIGH_LSB];
						end
						dspdp_pkg::PART_EXT: begin
							next_store_data = {{8{opa[dspdp_pkg::EXT_MSB]}}, opa[dspdp_pkg::EXT_MSB:dspdp_pkg::EXT_LSB]};
						end
						default: begin
							next_store_data = opa[dspdp_pkg::LOW_MSB:dspdp_pkg::LOW_LSB];
						end
					endcase
				end
				dspdp_pkg::OP_NOP: begin
					wr_en = 1'b0;
				end
				default: begin
					calc_val = alu_val;
					wr_en = 1'b1;
				end
			endcase
		end
		if (wr_en) begin
			wr_val = merge_parts(opd, calc_val, part_sel);
		end
	end

	// Next result and status flags follow every register write.
	always_comb begin
		next_result = result;
		next_result_valid = wr_en;
		next_flag_zero = flag_zero;
		next_flag_neg = flag_neg;
		if (wr_en) begin
			next_result = wr_val;
			next_flag_zero = (wr_val == 40'h00_0000_0000);
			next_flag_neg = wr_val[dspdp_pkg::EXT_MSB];
		end
	end

	// ***********************************************************************
	// Working register bank
	// ***********************************************************************

	// Each register takes the write value when it is the destination.
	for (genvar i = 0; i < dspdp_pkg::NUM_REGS; i++) begin : g_bank
		always_comb begin
			next_bank[i] = (wr_en && (dst_sel == 3'(i))) ? wr_val : bank[i];
		end
	end

	// Registers the bank and outputs at the edge that ends the operation cycle.
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int j = 0; j < dspdp_pkg::NUM_REGS; j++) begin
				bank[j] <= dspdp_pkg::REG_RESET;
			end
			store_data <= dspdp_pkg::STORE_RESET;
			store_valid <= 1'b0;
			result <= dspdp_pkg::REG_RESET;
			result_valid <= 1'b0;
			flag_zero <= 1'b0;
			flag_neg <= 1'b0;
		end else begin
			bank <= next_bank;
			store_data <= next_store_data;
			store_valid <= next_store_valid;
			result <= next_result;
			result_valid <= next_result_valid;
			flag_zero <= next_flag_zero;
			flag_neg <= next_flag_neg;
		end
	end

	// ***********************************************************************
	// Assertions
	// ***********************************************************************

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// The first edge after reset finds the first and last working registers cleared.
	a_bank_reset_clear: assert property ($fell(rst) |-> bank[0] == 40'h00_0000_0000 && bank[7] == 40'h00_0000_0000)
		else $error("working register not cleared by reset");

	// A whole-register add writes the 40-bit sum one cycle later.
	a_alu_add_sum: assert property (op_valid && op_code == dspdp_pkg::OP_ADD && part_sel == dspdp_pkg::PART_WHOLE
		|=> bank[$past(dst_sel)] == 40'($past(opa) + $past(opb)) && result_valid)
		else $error("add result wrong");

	// A multiply-subtract with no scaling takes the product from the destination.
	a_mac_sub_value: assert property (op_valid && op_code == dspdp_pkg::OP_MAC_SUB && prescale == dspdp_pkg::PSC_NONE &&
		part_sel == dspdp_pkg::PART_WHOLE
		|=> result == 40'($past(opd) - {{8{$past(product[31])}}, $past(product)}))
		else $error("multiply-subtract result wrong");

	// The long pre-scale copies the sign over the upper sixteen bits.
	a_prescale_long: assert property (prescale == dspdp_pkg::PSC_BY16
		|-> addend_scaled == {{16{opd[39]}}, opd[39:16]})
		else $error("pre-scaler by sixteen wrong");

	// The short pre-scale moves the value down by one with sign fill.
	a_prescale_short: assert property (prescale == dspdp_pkg::PSC_BY1
		|-> addend_scaled == {opd[39], opd[39:1]})
		else $error("pre-scaler by one wrong");

	// An arithmetic right shift keeps the sign in the top bit.
	a_sra_sign_fill: assert property (op_valid && op_code == dspdp_pkg::OP_SRA && part_sel == dspdp_pkg::PART_WHOLE
		|=> result[39] == $past(opa[39]) &&
		result[38] == (($past(shift_amt) == 6'h00) ? $past(opa[38]) :
		$past(opa[39])))
		else $error("arithmetic shift sign fill wrong");

	// A logical right shift by a nonzero distance clears the top bit.
	a_srl_zero_fill: assert property (op_valid && op_code == dspdp_pkg::OP_SRL && part_sel == dspdp_pkg::PART_WHOLE &&
		shift_amt != 6'h00 |=> !result[39] && !flag_neg)
		else $error("logical shift did not insert zero");

	// A left shift moves the operand up by the requested distance.
	a_shl_distance: assert property (op_valid && op_code == dspdp_pkg::OP_SHL && part_sel == dspdp_pkg::PART_WHOLE
		|=> result == 40'($past(opa) << $past(shift_amt)))
		else $error("left shift result wrong");

	// A low-part load changes only bits 15..0 of the destination.
	a_load_low_part: assert property (op_valid && op_code == dspdp_pkg::OP_LOAD && part_sel == dspdp_pkg::PART_LOW
		|=> bank[$past(dst_sel)][39:16] == $past(opd[39:16]) && bank[$past(dst_sel)][15:0] == $past(load_data))
		else $error("low-part load disturbed other parts");

	// An extension store returns the sign-extended bits 39..32 for one cycle.
	a_store_ext_part: assert property (op_valid && op_code == dspdp_pkg::OP_STORE && part_sel == dspdp_pkg::PART_EXT
		|=> store_valid && store_data == {{8{$past(opa[39])}}, $past(opa[39:32])} ##1 (store_valid == $past(op_valid &&
		op_code == dspdp_pkg::OP_STORE)))
		else $error("extension store wrong");

	// A high-part write leaves the extension and low parts alone.
	a_high_part_keep: assert property (op_valid && op_code == dspdp_pkg::OP_ADD && part_sel == dspdp_pkg::PART_HIGH
		|=> bank[$past(dst_sel)][39:32] == $past(opd[39:32]) && bank[$past(dst_sel)][15:0] == $past(opd[15:0]))
		else $error("high-part write disturbed other parts");

	// Without a valid operation nothing is written in the next cycle.
	a_idle_no_write: assert property (!op_valid |=> !result_valid && !store_valid && $stable(result))
		else $error("write without operation");

endmodule

// File: pkg/dspdp_pkg.sv
package dspdp_pkg;

	// ***********************************************************************
	// Working register geometry
	// ***********************************************************************

	// Number of working registers and their width.
	localparam int NUM_REGS = 8;
	localparam int REG_W = 40;
	localparam int SEL_W = 3;
	localparam int HALF_W = 16;
	localparam int EXT_W = 8;
	localparam int SHIFT_W = 6;

	// Field positions of the low, high and extension parts.
	localparam int LOW_LSB = 0;
	localparam int LOW_MSB = 15;
	localparam int HIGH_LSB = 16;
	localparam int HIGH_MSB = 31;
	localparam int EXT_LSB = 32;
	localparam int EXT_MSB = 39;

	// Values after reset.
	localparam logic [39:0] REG_RESET = 40'h00_0000_0000;
	localparam logic [15:0] STORE_RESET = 16'h0000;

	// Shift distances of the addend pre-scaler.
	localparam int PSC_SHORT = 1;
	localparam int PSC_LONG = 16;

	// Cycles from an accepted operation to its written result.
	localparam int OP_LATENCY = 1;

	// ***********************************************************************
	// Enumerations
	// ***********************************************************************

	// Operations issued by the instruction sequencer.
	typedef enum logic [3:0] {
		OP_NOP,
		OP_MAC_ADD,
		OP_MAC_SUB,
		OP_ADD,
		OP_SUB,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_MOV,
		OP_NEG,
		OP_SHL,
		OP_SRA,
		OP_SRL,
		OP_LOAD,
		OP_STORE
	} dspdp_op_e;

	// Part combinations of a working register.
	typedef enum logic [2:0] {
		PART_LOW,
		PART_HIGH,
		PART_EXT,
		PART_HL,
		PART_WHOLE
	} dspdp_part_e;

	// Addend pre-scaler settings.
	typedef enum logic [1:0] {
		PSC_NONE,
		PSC_BY1,
		PSC_BY16
	} dspdp_psc_e;

	// Barrel shifter modes.
	typedef enum logic [1:0] {
		SH_LEFT,
		SH_ARITH,
		SH_LOGIC
	} dspdp_shift_e;

endpackage

// File: pkg/dspdp_shift_if.sv
`timescale 1ns/1ps
interface dspdp_shift_if;

	// Operand, distance, mode and result of the barrel shifter.
	logic [39:0] operand;
	logic [5:0] amount;
	dspdp_pkg::dspdp_shift_e mode;
	logic [39:0] result;

	// The datapath drives the request and reads the result.
	modport user (
		output operand,
		output amount,
		output mode,
		input result
	);

	// The shifter reads the request and drives the result.
	modport unit (
		input operand,
		input amount,
		input mode,
		output result
	);

endinterface

// File: rtl/dspdp_shifter.sv
`timescale 1ns/1ps
module dspdp_shifter (
	// Shift request and result.
	dspdp_shift_if.unit sh
);

	// ***********************************************************************
	// Barrel shifter
	// ***********************************************************************

	// Shifts the 40-bit operand by any distance; distances of 40 or more empty it, except an arithmetic shift of a negative operand, which gives all ones.
	always_comb begin
		unique case (sh.mode)
			dspdp_pkg::SH_LEFT: begin
				sh.result = sh.operand << sh.amount;
			end
			dspdp_pkg::SH_ARITH: begin
				sh.result = $unsigned($signed(sh.operand) >>> sh.amount);
			end
			dspdp_pkg::SH_LOGIC: begin
				sh.result = sh.operand >> sh.amount;
			end
			default: begin
				sh.result = sh.operand;
			end
		endcase
	end

endmodule

// File: dv/dspdp_mem_model.sv
`timescale 1ns/1ps
// ************************************************************
// Data memory model on the load and store buses
// ************************************************************
module dspdp_mem_model (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Load request and word.
	input wire logic rd_en,
	input wire logic [3:0] rd_addr,
	output logic [15:0] load_data,
	// Store bus from the datapath.
	input wire logic [15:0] store_data,
	input wire logic store_valid
);
	logic [15:0] mem [16];
	logic [15:0] idle_word;
	logic [3:0] wr_ptr;

	// Preset words mix negative and positive values.
	initial begin
		idle_word = 16'hA5A5;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'h9E37 * 16'(i + 1);
		end
	end

	// Stores fill consecutive words from 8; an unused bus toggles so stale data never looks valid.
	always @(posedge clock) begin
		if (rst) begin
			wr_ptr <= 4'h8;
		end else if (store_valid) begin
			mem[wr_ptr] <= store_data;
			wr_ptr <= wr_ptr + 4'h1;
		end
		if (!rd_en) begin
			idle_word <= ~idle_word;
		end
	end

	// Only a requested load shows a memory word.
	assign load_data = rd_en ? mem[rd_addr] : idle_word;
endmodule

// File: dv/dsp_40bit_arith_datapath_tb_top.sv
`timescale 1ns/1ps
module dsp_40bit_arith_datapath_tb_top;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic clock;
	logic rst;
	logic op_valid;
	dspdp_pkg::dspdp_op_e op_code;
	logic [2:0] dst_sel;
	logic [2:0] src_a_sel;
	logic [2:0] src_b_sel;
	dspdp_pkg::dspdp_part_e part_sel;
	dspdp_pkg::dspdp_psc_e prescale;
	logic [5:0] shift_amt;
	logic [15:0] load_data;
	logic [15:0] store_data;
	logic store_valid;
	logic [39:0] result;
	logic result_valid;
	logic flag_zero;
	logic flag_neg;
	logic rd_en;
	logic [3:0] rd_addr;
	logic [39:0] bank [8];
	int errors;
	int check_count;

	dspdp_datapath dut (.clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code), .dst_sel(dst_sel),
		.src_a_sel(src_a_sel), .src_b_sel(src_b_sel), .part_sel(part_sel), .prescale(prescale),
		.shift_amt(shift_amt), .load_data(load_data), .store_data(store_data), .store_valid(store_valid),
		.result(result), .result_valid(result_valid), .flag_zero(flag_zero), .flag_neg(flag_neg));

	dspdp_mem_model mem_model (.clock(clock), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr),
		.load_data(load_data), .store_data(store_data), .store_valid(store_valid));

	// The clock toggles every half period of 20 ns.
	always #20 clock = ~clock;

	// ************************************************************
	// Compare and closing tasks
	// ************************************************************
	task automatic check40(input logic [39:0] got, input logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t result %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t stored word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Reference and drivers
	// ************************************************************
	// Writes only the selected fields of a computed value into the old register value.
	function automatic logic [39:0] merge(input logic [39:0] o, input logic [39:0] v,
		input dspdp_pkg::dspdp_part_e p);
		case (p)
			dspdp_pkg::PART_LOW: return {o[39:16], v[15:0]};
			dspdp_pkg::PART_HIGH: return {o[39:32], v[31:16], o[15:0]};
			dspdp_pkg::PART_EXT: return {v[39:32], o[31:0]};
			dspdp_pkg::PART_HL: return {o[39:32], v[31:0]};
			default: return v;
		endcase
	endfunction

	// Presents one operation at a falling edge and judges the answer one cycle later.
	task automatic run_op(input dspdp_pkg::dspdp_op_e op, input logic [2:0] d, input logic [2:0] a,
		input logic [2:0] b, input dspdp_pkg::dspdp_part_e p, input logic [3:0] ra = 4'h0,
		input logic [5:0] amt = 6'h00, input dspdp_pkg::dspdp_psc_e s = dspdp_pkg::PSC_NONE);
		logic [39:0] x;
		logic [39:0] y;
		logic [39:0] v;
		logic [39:0] n;
		logic signed [39:0] sa;
		logic signed [39:0] xs;
		logic signed [15:0] ha;
		logic signed [15:0] hb;
		logic signed [31:0] pr;
		logic [15:0] w;
		logic [15:0] sw;
		op_valid = 1'h1;
		op_code = op;
		dst_sel = d;
		src_a_sel = a;
		src_b_sel = b;
		part_sel = p;
		prescale = s;
		shift_amt = amt;
		rd_en = (op == dspdp_pkg::OP_LOAD);
		rd_addr = ra;
		#1;
		x = bank[a];
		y = bank[b];
		w = load_data;
		sa = bank[d];
		xs = x;
		ha = x[31:16];
		hb = y[31:16];
		pr = ha * hb;
		case (s)
			dspdp_pkg::PSC_BY1: n = sa >>> 1;
			dspdp_pkg::PSC_BY16: n = sa >>> 16;
			default: n = sa;
		endcase
		case (op)
			dspdp_pkg::OP_MAC_ADD: v = n + {{8{pr[31]}}, pr};
			dspdp_pkg::OP_MAC_SUB: v = n - {{8{pr[31]}}, pr};
			dspdp_pkg::OP_ADD: v = x + y;
			dspdp_pkg::OP_SUB: v = x - y;
			dspdp_pkg::OP_AND: v = x & y;
			dspdp_pkg::OP_OR: v = x | y;
			dspdp_pkg::OP_XOR: v = x ^ y;
			dspdp_pkg::OP_NEG: v = -x;
			dspdp_pkg::OP_SHL: v = x << amt;
			dspdp_pkg::OP_SRA: v = xs >>> amt;
			dspdp_pkg::OP_SRL: v = x >> amt;
			dspdp_pkg::OP_LOAD: v = (p == dspdp_pkg::PART_WHOLE) ? {{24{w[15]}}, w} :
				(p == dspdp_pkg::PART_LOW) ? {24'h00_0000, w} : {w[7:0], w, 16'h0000};
			default: v = x;
		endcase
		case (p)
			dspdp_pkg::PART_LOW, dspdp_pkg::PART_WHOLE: sw = x[15:0];
			dspdp_pkg::PART_EXT: sw = {{8{x[39]}}, x[39:32]};
			default: sw = x[31:16];
		endcase
		n = merge(bank[d], v, p);
		@(negedge clock);
		if (op == dspdp_pkg::OP_STORE) begin
			check1(store_valid, 1'h1);
			check16(store_data, sw);
			check1(result_valid, 1'h0);
		end else if (op == dspdp_pkg::OP_NOP) begin
			check1(result_valid, 1'h0);
			check1(store_valid, 1'h0);
		end else begin
			check1(result_valid, 1'h1);
			check40(result, n);
			check1(flag_zero, n == 40'h00_0000_0000);
			check1(flag_neg, n[39]);
			bank[d] = n;
		end
	endtask

	// Drops the request for one cycle; the pulses must be gone.
	task automatic idle_cycle();
		op_valid = 1'h0;
		rd_en = 1'h0;
		@(negedge clock);
		check1(result_valid, 1'h0);
		check1(store_valid, 1'h0);
	endtask

	// Holds reset for the given cycles and checks the cleared outputs.
	task automatic do_reset(input int cycles);
		rst = 1'h1;
		op_valid = 1'h0;
		rd_en = 1'h0;
		repeat (cycles) @(negedge clock);
		rst = 1'h0;
		for (int i = 0; i < 8; i++) begin
			bank[i] = dspdp_pkg::REG_RESET;
		end
		@(negedge clock);
		check40(result, dspdp_pkg::REG_RESET);
		check16(store_data, dspdp_pkg::STORE_RESET);
		check1(result_valid, 1'h0);
		check1(store_valid, 1'h0);
		check1(flag_zero, 1'h0);
		check1(flag_neg, 1'h0);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	// Fills all eight registers, builds one from its parts, stores every part and reads back.
	task automatic scen_load_store();
		for (int i = 0; i < 8; i++) begin
			run_op(dspdp_pkg::OP_LOAD, 3'(i), 3'h0, 3'h0, dspdp_pkg::PART_WHOLE, 4'(i));
		end
		run_op(dspdp_pkg::OP_LOAD, 3'h1, 3'h0, 3'h0, dspdp_pkg::PART_LOW, 4'h4);
		run_op(dspdp_pkg::OP_LOAD, 3'h1, 3'h0, 3'h0, dspdp_pkg::PART_HIGH, 4'h1);
		run_op(dspdp_pkg::OP_LOAD, 3'h1, 3'h0, 3'h0, dspdp_pkg::PART_EXT, 4'h0);
		run_op(dspdp_pkg::OP_LOAD, 3'h2, 3'h0, 3'h0, dspdp_pkg::PART_HL, 4'h3);
		for (int k = dspdp_pkg::PART_LOW; k <= dspdp_pkg::PART_WHOLE; k++) begin
			run_op(dspdp_pkg::OP_STORE, 3'h0, 3'h1, 3'h0, dspdp_pkg::dspdp_part_e'(k));
		end
		idle_cycle();
		run_op(dspdp_pkg::OP_LOAD, 3'h6, 3'h0, 3'h0, dspdp_pkg::PART_WHOLE, 4'hA);
	endtask

	// Runs every logic and arithmetic code back to back, a zero result and partial writes.
	task automatic scen_alu();
		for (int k = dspdp_pkg::OP_ADD; k <= dspdp_pkg::OP_NEG; k++) begin
			run_op(dspdp_pkg::dspdp_op_e'(k), 3'(k - 3), 3'h1, 3'h2, dspdp_pkg::PART_WHOLE);
		end
		run_op(dspdp_pkg::OP_SUB, 3'h7, 3'h3, 3'h3, dspdp_pkg::PART_WHOLE);
		for (int k = dspdp_pkg::PART_LOW; k <= dspdp_pkg::PART_HL; k++) begin
			run_op(dspdp_pkg::OP_ADD, 3'h5, 3'h1, 3'h5, dspdp_pkg::dspdp_part_e'(k));
		end
	endtask

	// Shifts a negative operand in all three modes over boundary distances.
	task automatic scen_shift();
		logic [5:0] amts [6] = '{6'h00, 6'h01, 6'h10, 6'h27, 6'h28, 6'h3F};
		run_op(dspdp_pkg::OP_LOAD, 3'h1, 3'h0, 3'h0, dspdp_pkg::PART_WHOLE, 4'h0);
		run_op(dspdp_pkg::OP_LOAD, 3'h1, 3'h0, 3'h0, dspdp_pkg::PART_HIGH, 4'h1);
		for (int m = dspdp_pkg::OP_SHL; m <= dspdp_pkg::OP_SRL; m++) begin
			for (int j = 0; j < 6; j++) begin
				run_op(dspdp_pkg::dspdp_op_e'(m), 3'h6, 3'h1, 3'h0, dspdp_pkg::PART_WHOLE, 4'h0, amts[j]);
			end
		end
	endtask

	// Accumulates into a negative register with each pre-scaler setting.
	task automatic scen_mac();
		run_op(dspdp_pkg::OP_LOAD, 3'h3, 3'h0, 3'h0, dspdp_pkg::PART_WHOLE, 4'h2);
		for (int s = dspdp_pkg::PSC_NONE; s <= dspdp_pkg::PSC_BY16; s++) begin
			run_op(dspdp_pkg::OP_MAC_ADD, 3'h3, 3'h1, 3'h2, dspdp_pkg::PART_WHOLE, 4'h0, 6'h00,
				dspdp_pkg::dspdp_psc_e'(s));
			run_op(dspdp_pkg::OP_MAC_SUB, 3'h3, 3'h1, 3'h3, dspdp_pkg::PART_WHOLE, 4'h0, 6'h00,
				dspdp_pkg::dspdp_psc_e'(s));
		end
	endtask

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	// Sets every input at time zero, then runs the scenarios and a mid-run reset.
	initial begin
		clock = 1'h0;
		errors = 0;
		check_count = 0;
		op_code = dspdp_pkg::OP_NOP;
		dst_sel = 3'h0;
		src_a_sel = 3'h0;
		src_b_sel = 3'h0;
		part_sel = dspdp_pkg::PART_WHOLE;
		prescale = dspdp_pkg::PSC_NONE;
		shift_amt = 6'h00;
		rd_addr = 4'h0;
		do_reset(6);
		scen_load_store();
		scen_alu();
		scen_shift();
		scen_mac();
		run_op(dspdp_pkg::OP_NOP, 3'h1, 3'h2, 3'h3, dspdp_pkg::PART_WHOLE);
		idle_cycle();
		do_reset(1);
		run_op(dspdp_pkg::OP_STORE, 3'h0, 3'h1, 3'h0, dspdp_pkg::PART_HIGH);
		complete_run();
	end

	// Cuts a hang short well after the roughly 70 cycles the scenarios need.
	initial begin
		repeat (3000) @(posedge clock);
		errors++;
		complete_run();
	end
endmodule
